/* File: core/ipr_pkg.sv */
// Shared constants, register map and carrier types of the interrupt priority register slice.
// Assumes a 32-bit classic Wishbone slave port and one 10 MHz system clock.
package ipr_pkg;

	// Sizes of the slice.
	localparam int IPR_NREG   = 7;
	localparam int IPR_NSRC   = 16;
	localparam int IPR_ADR_W  = 8;
	localparam int IPR_DAT_W  = 32;
	localparam int IPR_REG_W  = 16;
	localparam int IPR_PRIO_W = 3;

	// Register word indices; the byte address is four times the index.
	localparam logic [2:0] IPR_IDX_TIMER4_OUTCMP34      = 3'h0;
	localparam logic [2:0] IPR_IDX_UART2_EXTINT2_TIMER5 = 3'h1;
	localparam logic [2:0] IPR_IDX_SPI2                 = 3'h2;
	localparam logic [2:0] IPR_IDX_INCAP345             = 3'h3;
	localparam logic [2:0] IPR_IDX_OUTCMP5              = 3'h4;
	localparam logic [2:0] IPR_IDX_PARALLEL_PORT        = 3'h5;
	localparam logic [2:0] IPR_IDX_I2C2                 = 3'h6;

	// Field positions inside a 16-bit priority register.
	localparam int IPR_POS_F3 = 12;
	localparam int IPR_POS_F2 = 8;
	localparam int IPR_POS_F1 = 4;
	localparam int IPR_POS_F0 = 0;

	// Implemented bits of each register; everything else is unused.
	localparam logic [15:0] IPR_MASK_TIMER4_OUTCMP34      = 16'h7770;
	localparam logic [15:0] IPR_MASK_UART2_EXTINT2_TIMER5 = 16'h7777;
	localparam logic [15:0] IPR_MASK_SPI2                 = 16'h0077;
	localparam logic [15:0] IPR_MASK_INCAP345             = 16'h7770;
	localparam logic [15:0] IPR_MASK_OUTCMP5              = 16'h0070;
	localparam logic [15:0] IPR_MASK_PARALLEL_PORT        = 16'h0070;
	localparam logic [15:0] IPR_MASK_I2C2                 = 16'h0770;

	// Every field wakes up at level four: upper bit set, lower two clear.
	localparam logic [15:0] IPR_RST_FIELDS = 16'h4444;

	// Priority codes.
	localparam logic [2:0] IPR_PRIO_OFF = 3'h0;
	localparam logic [2:0] IPR_PRIO_MIN = 3'h1;
	localparam logic [2:0] IPR_PRIO_MAX = 3'h7;

	// Bit of each source in the request and pending vectors.
	localparam int IPR_SRC_TIMER4        = 0;
	localparam int IPR_SRC_OUTCMP4       = 1;
	localparam int IPR_SRC_OUTCMP3       = 2;
	localparam int IPR_SRC_UART2_TX      = 3;
	localparam int IPR_SRC_UART2_RX      = 4;
	localparam int IPR_SRC_EXTINT2       = 5;
	localparam int IPR_SRC_TIMER5        = 6;
	localparam int IPR_SRC_SPI2_EVENT    = 7;
	localparam int IPR_SRC_SPI2_FAULT    = 8;
	localparam int IPR_SRC_INCAP5        = 9;
	localparam int IPR_SRC_INCAP4        = 10;
	localparam int IPR_SRC_INCAP3        = 11;
	localparam int IPR_SRC_OUTCMP5       = 12;
	localparam int IPR_SRC_PARALLEL_PORT = 13;
	localparam int IPR_SRC_I2C2_MASTER   = 14;
	localparam int IPR_SRC_I2C2_SLAVE    = 15;

	// Priorities handed to arbitration; the last field sits at bits 2:0, matching source 0.
	typedef struct packed {
		logic [2:0] i2c2_slave_prio;
		logic [2:0] i2c2_master_prio;
		logic [2:0] parallel_port_prio;
		logic [2:0] outcmp5_prio;
		logic [2:0] incap3_prio;
		logic [2:0] incap4_prio;
		logic [2:0] incap5_prio;
		logic [2:0] spi2_fault_prio;
		logic [2:0] spi2_event_prio;
		logic [2:0] timer5_prio;
		logic [2:0] extint2_prio;
		logic [2:0] uart2_rx_prio;
		logic [2:0] uart2_tx_prio;
		logic [2:0] outcmp3_prio;
		logic [2:0] outcmp4_prio;
		logic [2:0] timer4_prio;
	} ipr_prio_t;

	// Classic Wishbone request from the master.
	typedef struct packed {
		logic                 cyc;
		logic                 stb;
		logic                 we;
		logic [IPR_ADR_W-1:0] adr;
		logic [3:0]           sel;
		logic [IPR_DAT_W-1:0] dat;
	} ipr_wb_req_t;

	// Classic Wishbone answer from this slave.
	typedef struct packed {
		logic                 ack;
		logic [IPR_DAT_W-1:0] dat;
	} ipr_wb_rsp_t;

	// Implemented-bit mask of a register index; unknown indices have none.
	function automatic logic [15:0] ipr_impl_mask(input logic [2:0] idx);
		unique case (idx)
			IPR_IDX_TIMER4_OUTCMP34:      ipr_impl_mask = IPR_MASK_TIMER4_OUTCMP34;
			IPR_IDX_UART2_EXTINT2_TIMER5: ipr_impl_mask = IPR_MASK_UART2_EXTINT2_TIMER5;
			IPR_IDX_SPI2:                 ipr_impl_mask = IPR_MASK_SPI2;
			IPR_IDX_INCAP345:             ipr_impl_mask = IPR_MASK_INCAP345;
			IPR_IDX_OUTCMP5:              ipr_impl_mask = IPR_MASK_OUTCMP5;
			IPR_IDX_PARALLEL_PORT:        ipr_impl_mask = IPR_MASK_PARALLEL_PORT;
			IPR_IDX_I2C2:                 ipr_impl_mask = IPR_MASK_I2C2;
			default:                      ipr_impl_mask = 16'h0000;
		endcase
	endfunction

endpackage

/* File: core/ipr_pend_gate.sv */
// Pending gate: masks raw source requests with their priority fields and finds the top level.
// Assumes requests come from logic on the same clock, so no synchroniser is needed.
`timescale 1ns/1ns
module ipr_pend_gate
	import ipr_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                nrst,
	input  wire ipr_prio_t           prio,
	input  wire logic [IPR_NSRC-1:0] src_req,
	output logic      [IPR_NSRC-1:0] src_pend,
	output logic      [2:0]          pend_level
);

	logic [IPR_NSRC-1:0] pend_r;
	logic [IPR_NSRC-1:0] pend_nxt;
	logic [2:0]          level_r;
	logic [2:0]          level_nxt;
	logic [IPR_NSRC*IPR_PRIO_W-1:0] flat;

	// The packed struct puts source i at bits 3i+2:3i.
	assign flat = prio;

	// A zero field hides its source entirely; the code is the level itself, 1 lowest, 7 highest.
	always_comb begin
		pend_nxt  = '0;
		level_nxt = IPR_PRIO_OFF;
		for (int i = 0; i < IPR_NSRC; i++) begin
			if (src_req[i] && (flat[i*IPR_PRIO_W +: IPR_PRIO_W] != IPR_PRIO_OFF)) begin // R3
				pend_nxt[i] = 1'b1;
				if (flat[i*IPR_PRIO_W +: IPR_PRIO_W] > level_nxt) begin // R1 R2
					level_nxt = flat[i*IPR_PRIO_W +: IPR_PRIO_W];
				end
			end
		end
	end

	// Registered so the outputs leave on flip-flops; this costs one cycle of latency.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pend_r  <= '0;
			level_r <= IPR_PRIO_OFF;
		end else begin
			pend_r  <= pend_nxt;
			level_r <= level_nxt;
		end
	end

	assign src_pend   = pend_r;
	assign pend_level = level_r;

endmodule

/* File: core/ipr_regs.sv */
// Interrupt priority registers six to twelve with a classic Wishbone slave port.
// Assumes a single 10 MHz clock, synchronous active-low reset and same-clock source requests.
//
// What this block does
// [R1] A three-bit field holding 111 gives its source level 7, the highest user level.
// [R2] A field holding 001 gives level 1, the lowest enabled level, with codes between linear.
// [R3] A field holding 000 disables its source so it is never shown as pending.
// [R4] Unused register bits ignore writes and always read back as zero.
// [R5] At reset every implemented field loads 100, level four, and all field bits are R/W.
// [R6] Register six holds timer 4 at 14-12, compare 4 at 10-8 and compare 3 at 6-4.
// [R7] Register seven holds UART2 tx 14-12, UART2 rx 10-8, ext int 2 6-4, timer 5 2-0.
// [R8] Register eight holds SPI2 event at 6-4 and SPI2 fault at 2-0, bits 15-7 unused.
// [R9] Register nine holds capture 5 at 14-12, capture 4 at 10-8 and capture 3 at 6-4.
// [R10] Register ten holds only compare 5 at 6-4, all other bits reading zero.
// [R11] Register eleven holds only the parallel port priority at 6-4, all else zero.
// [R12] Register twelve holds I2C2 master at 10-8 and I2C2 slave at 6-4, bits 15-11 unused.
// [R13] Each field's current value is the priority given to arbitration from the next cycle.
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ns
module ipr_regs
	import ipr_pkg::*;
(
	input  wire logic                CLK,
	input  wire logic                NRST,
	input  wire ipr_wb_req_t         WB_REQ,
	output ipr_wb_rsp_t              WB_RSP,
	input  wire logic [IPR_NSRC-1:0] SRC_REQ,
	output ipr_prio_t                PRIO,
	output logic      [IPR_NSRC-1:0] SRC_PEND,
	output logic      [2:0]          PEND_LEVEL
);

	// Register storage, one 16-bit word per index.
	logic [IPR_REG_W-1:0] regs_r   [IPR_NREG];
	logic [IPR_REG_W-1:0] regs_nxt [IPR_NREG];

	// Bus answer state.
	logic                 ack_r;
	logic                 ack_nxt;
	logic [IPR_DAT_W-1:0] rdat_r;
	logic [IPR_DAT_W-1:0] rdat_nxt;

	// Decoded request.
	logic                 req_live;
	logic                 req_start;
	logic                 req_commit;
	logic [3:0]           dec;
	logic                 hit;
	logic [2:0]           idx;
	logic [IPR_REG_W-1:0] lane_mask;

	// Split a byte address into a hit flag and a word index.
	// Anything above the seventh word, or with high address bits set, misses.
	function automatic logic [3:0] ipr_decode(input logic [IPR_ADR_W-1:0] adr);
		logic [2:0] w;
		w = adr[4:2];
		if ((adr[IPR_ADR_W-1:5] == 3'h0) && (w <= IPR_IDX_I2C2)) begin
			ipr_decode = {1'b1, w};
		end else begin
			ipr_decode = 4'h0;
		end
	endfunction

	// Replace only the bits that are both writable and enabled by the byte lanes.
	function automatic logic [15:0] ipr_merge(
		input logic [15:0] old,
		input logic [15:0] wdat,
		input logic [15:0] wmask
	);
		ipr_merge = (old & ~wmask) | (wdat & wmask);
	endfunction

	// Pick one three-bit field out of a register.
	function automatic logic [2:0] ipr_field(input logic [15:0] r, input int pos);
		ipr_field = r[pos +: IPR_PRIO_W];
	endfunction

	// Request qualification. The first cycle of a request produces the answer,
	// and the edge at which the master sees ack high is the one that commits a write.
	assign req_live   = WB_REQ.cyc && WB_REQ.stb;
	assign req_start  = req_live && !ack_r;
	assign req_commit = req_live && ack_r;
	assign dec        = ipr_decode(WB_REQ.adr);
	assign hit        = dec[3];
	assign idx        = dec[2:0];

	// Only the two low byte lanes carry register data; the upper lanes are ignored.
	assign lane_mask = {{8{WB_REQ.sel[1]}}, {8{WB_REQ.sel[0]}}};

	// Next register values. A write touches only implemented bits of the addressed word,
	// so the unused positions can never pick up a one.
	always_comb begin
		for (int i = 0; i < IPR_NREG; i++) begin
			regs_nxt[i] = regs_r[i];
		end
		if (req_commit && WB_REQ.we && hit) begin
			regs_nxt[idx] = ipr_merge(regs_r[idx], WB_REQ.dat[IPR_REG_W-1:0],
				ipr_impl_mask(idx) & lane_mask); // R4
		end
	end

	// Register storage. Reset leaves every implemented field at level four.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			for (int i = 0; i < IPR_NREG; i++) begin
				regs_r[i] <= ipr_impl_mask(i[2:0]) & IPR_RST_FIELDS; // R5
			end
		end else begin
			for (int i = 0; i < IPR_NREG; i++) begin
				regs_r[i] <= regs_nxt[i];
			end
		end
	end

	// Next answer. Ack rises one edge after the request and falls on the edge after,
	// so a master that drops stb after ack sees exactly one ack per request.
	// Unmapped addresses are still acknowledged, reading zero and dropping writes,
	// so a stray access cannot hang the bus.
	always_comb begin
		ack_nxt  = req_start;
		rdat_nxt = '0;
		if (req_start && hit && !WB_REQ.we) begin
			rdat_nxt = {16'h0000, regs_r[idx] & ipr_impl_mask(idx)}; // R4
		end
	end

	// Answer registers.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			ack_r  <= 1'b0;
			rdat_r <= '0;
		end else begin
			ack_r  <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	assign WB_RSP.ack = ack_r;
	assign WB_RSP.dat = rdat_r;

	// Register six: timer 4, output compare 4 and 3.
	assign PRIO.timer4_prio  = ipr_field(regs_r[IPR_IDX_TIMER4_OUTCMP34], IPR_POS_F3); // R6
	assign PRIO.outcmp4_prio = ipr_field(regs_r[IPR_IDX_TIMER4_OUTCMP34], IPR_POS_F2); // R6
	assign PRIO.outcmp3_prio = ipr_field(regs_r[IPR_IDX_TIMER4_OUTCMP34], IPR_POS_F1); // R6

	// Register seven: UART2 transmit and receive, external interrupt 2, timer 5.
	assign PRIO.uart2_tx_prio =
		ipr_field(regs_r[IPR_IDX_UART2_EXTINT2_TIMER5], IPR_POS_F3); // R7
	assign PRIO.uart2_rx_prio =
		ipr_field(regs_r[IPR_IDX_UART2_EXTINT2_TIMER5], IPR_POS_F2); // R7
	assign PRIO.extint2_prio =
		ipr_field(regs_r[IPR_IDX_UART2_EXTINT2_TIMER5], IPR_POS_F1); // R7
	assign PRIO.timer5_prio =
		ipr_field(regs_r[IPR_IDX_UART2_EXTINT2_TIMER5], IPR_POS_F0); // R7

	// Register eight: SPI2 event and fault.
	assign PRIO.spi2_event_prio = ipr_field(regs_r[IPR_IDX_SPI2], IPR_POS_F1); // R8
	assign PRIO.spi2_fault_prio = ipr_field(regs_r[IPR_IDX_SPI2], IPR_POS_F0); // R8

	// Register nine: input capture 5, 4 and 3.
	assign PRIO.incap5_prio = ipr_field(regs_r[IPR_IDX_INCAP345], IPR_POS_F3); // R9
	assign PRIO.incap4_prio = ipr_field(regs_r[IPR_IDX_INCAP345], IPR_POS_F2); // R9
	assign PRIO.incap3_prio = ipr_field(regs_r[IPR_IDX_INCAP345], IPR_POS_F1); // R9

	// Registers ten and eleven carry one field each.
	assign PRIO.outcmp5_prio = ipr_field(regs_r[IPR_IDX_OUTCMP5], IPR_POS_F1); // R10
	assign PRIO.parallel_port_prio =
		ipr_field(regs_r[IPR_IDX_PARALLEL_PORT], IPR_POS_F1); // R11

	// Register twelve: I2C2 master and slave events.
	assign PRIO.i2c2_master_prio = ipr_field(regs_r[IPR_IDX_I2C2], IPR_POS_F2); // R12
	assign PRIO.i2c2_slave_prio  = ipr_field(regs_r[IPR_IDX_I2C2], IPR_POS_F1); // R12

	// The gate reads the live fields, so a committed write steers the very next
	// decision; the one-cycle gate register is the only lag.
	ipr_pend_gate u_gate (
		.clk        (CLK),
		.nrst       (NRST),
		.prio       (PRIO), // R13
		.src_req    (SRC_REQ),
		.src_pend   (SRC_PEND),
		.pend_level (PEND_LEVEL)
	);

endmodule

/* File: testbench/ipr_regs_checker.sv */
// Port-level assertions for the interrupt priority register slice.
// Assumes it is bound into ipr_regs and sees only that module's ports.
`timescale 1ns/1ns
module ipr_regs_checker
	import ipr_pkg::*;
(
	input wire logic                CLK,
	input wire logic                NRST,
	input wire ipr_wb_req_t         WB_REQ,
	input wire ipr_wb_rsp_t         WB_RSP,
	input wire logic [IPR_NSRC-1:0] SRC_REQ,
	input wire ipr_prio_t           PRIO,
	input wire logic [IPR_NSRC-1:0] SRC_PEND,
	input wire logic [2:0]          PEND_LEVEL
);
	logic [47:0] pv;
	logic [15:0] en;
	logic [2:0]  lvl;
	logic        wr_ack;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	// Enabled sources and top requested level; a zero field can never win.
	always_comb begin
		pv = PRIO;
		lvl = 3'h0;
		for (int i = 0; i < IPR_NSRC; i++) begin
			en[i] = pv[3*i +: 3] != 3'h0;
			if (SRC_REQ[i] && pv[3*i +: 3] > lvl) begin
				lvl = pv[3*i +: 3];
			end
		end
	end
	// A write lands only at the edge that carries its acknowledge.
	assign wr_ack = WB_REQ.cyc & WB_REQ.stb & WB_REQ.we & WB_RSP.ack;
	property p_answer;
		WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack |=> WB_RSP.ack;
	endproperty
	a_answer: assert property (p_answer) else $error("ack missing");
	property p_rdat;
		WB_RSP.dat[31:16] == 16'h0 && (WB_RSP.ack || WB_RSP.dat == 32'h0);
	endproperty
	a_rdat: assert property (p_rdat) else $error("stray read data");
	property p_reset;
		disable iff (1'b0) !NRST |=> PRIO == 48'h924924924924;
	endproperty
	a_reset: assert property (p_reset) else $error("reset level");
	property p_hold;
		!wr_ack |=> $stable(PRIO);
	endproperty
	a_hold: assert property (p_hold) else $error("field moved");
	property p_gate;
		$past(NRST) |-> SRC_PEND == $past(SRC_REQ & en);
	endproperty
	a_gate: assert property (p_gate) else $error("pending mask");
	property p_level;
		$past(NRST) |-> PEND_LEVEL == $past(lvl);
	endproperty
	a_level: assert property (p_level) else $error("pending level");
	property p_timer4;
		wr_ack && WB_REQ.adr == 8'h00 && WB_REQ.sel[1] |=>
			PRIO.timer4_prio == $past(WB_REQ.dat[14:12]);
	endproperty
	a_timer4: assert property (p_timer4) else $error("timer4 field");
	property p_i2c2m;
		wr_ack && WB_REQ.adr == 8'h18 && WB_REQ.sel[1] |=>
			PRIO.i2c2_master_prio == $past(WB_REQ.dat[10:8]);
	endproperty
	a_i2c2m: assert property (p_i2c2m) else $error("i2c2 field");
	c_write: cover property (wr_ack);
	c_read: cover property (WB_RSP.ack && !WB_REQ.we);
	c_top: cover property (PEND_LEVEL == 3'h7);
endmodule
bind ipr_regs ipr_regs_checker i_checker (.CLK(CLK), .NRST(NRST), .WB_REQ(WB_REQ),
	.WB_RSP(WB_RSP), .SRC_REQ(SRC_REQ), .PRIO(PRIO), .SRC_PEND(SRC_PEND),
	.PEND_LEVEL(PEND_LEVEL));

/* File: testbench/tb.sv */
// Self-checking bench for the interrupt priority register slice.
// Assumes the package, ipr_regs and its checker are compiled first.
`timescale 1ns/1ns
module tb
	import ipr_pkg::*;
;
	localparam logic [15:0] MSK [7] = '{16'h7770, 16'h7777, 16'h0077, 16'h7770,
		16'h0070, 16'h0070, 16'h0770};
	localparam logic [15:0] PAT [7] = '{16'h7530, 16'h1234, 16'h0065, 16'h2610,
		16'h0070, 16'h0020, 16'h0530};
	logic                clk = 1'b0;
	logic                nrst = 1'b0;
	ipr_wb_req_t         req = '0;
	ipr_wb_rsp_t         rsp;
	logic [IPR_NSRC-1:0] src_req = '0;
	ipr_prio_t           prio;
	logic [IPR_NSRC-1:0] src_pend;
	logic [2:0]          pend_level;
	int                  failures = 0;
	int                  checks_done = 0;
	ipr_regs i_dut (.CLK(clk), .NRST(nrst), .WB_REQ(req), .WB_RSP(rsp), .SRC_REQ(src_req),
		.PRIO(prio), .SRC_PEND(src_pend), .PEND_LEVEL(pend_level));
	// A 100 ns clock.
	always #50 clk = ~clk;
	// One classic cycle; the request holds until ack is sampled high.
	// No cycle count is assumed here, so a missing ack is left to the watchdog.
	task automatic wb_acc(input logic w, input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s, output logic [31:0] q);
		@(posedge clk);
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: {16'h0, d}};
		do begin
			@(posedge clk);
		end while (rsp.ack !== 1'b1);
		q = rsp.dat;
		req <= '0;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pend(input logic [15:0] p, input logic [2:0] l);
		chk({29'h0, src_pend, pend_level}, {29'h0, p, l});
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		logic [31:0] q;
		wb_acc(1'b0, a, 16'h0, 4'h3, q);
		chk({16'h0, q}, {32'h0, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
		logic [31:0] q;
		wb_acc(1'b1, a, d, s, q);
	endtask
	// Pending outputs lag by one edge, so two edges pass before a look.
	task automatic settle();
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic print_verdict();
		if (failures == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Main sequence of register and pending tests.
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rd(8'(4*i), 16'h4444 & MSK[i]);
			wr(8'(4*i), 16'hFFFF, 4'h3);
			rd(8'(4*i), MSK[i]);
			wr(8'(4*i), 16'h0000, 4'h3);
			rd(8'(4*i), 16'h0000);
		end
		wr(8'h04, 16'h1234, 4'h1);
		rd(8'h04, 16'h0034);
		wr(8'h04, 16'h5678, 4'h2);
		rd(8'h04, 16'h5634);
		wr(8'h1C, 16'hFFFF, 4'h3);
		rd(8'h1C, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			wr(8'(4*i), PAT[i], 4'h3);
		end
		src_req <= 16'hFFFF;
		settle();
		chk(prio, {3'h3, 3'h5, 3'h2, 3'h7, 3'h1, 3'h6, 3'h2, 3'h5, 3'h6, 3'h4, 3'h3,
			3'h2, 3'h1, 3'h3, 3'h5, 3'h7});
		chk_pend(16'hFFFF, 3'h7);
		wr(8'h00, 16'h0000, 4'h3);
		wr(8'h10, 16'h0000, 4'h3);
		settle();
		chk_pend(16'hEFF8, 3'h6);
		@(posedge clk);
		src_req <= 16'h0040;
		// Every code of the timer 5 field, with only that source requesting.
		for (int k = 0; k < 8; k++) begin
			wr(8'h04, 16'(k), 4'h3);
			settle();
			chk_pend(k == 0 ? 16'h0000 : 16'h0040, 3'(k));
		end
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chk(prio, 48'h924924924924);
		rd(8'h18, 16'h0440);
		print_verdict();
	end
	// Cuts a hang short; the sequence needs well under a thousand cycles.
	initial begin
		#500000;
		failures++;
		print_verdict();
	end
endmodule
